/* src/ewb_pkg.sv */
// Package of constants and types for the external bus wait and bank control block.
package ewb_pkg;
  // Register indices on the plain register port.
  localparam logic [1:0] WAIT_CFG_OFS = 2'h0; // Wait count configuration register.
  localparam logic [1:0] BANK_CFG_OFS = 2'h1; // Bank boundary control register.
  localparam logic [1:0] STATUS_OFS = 2'h2; // Live status register.
  // Wait count configuration field positions, 3 bits per block.
  localparam int PROG_LO_POS = 0; // Program block 0000h-7fffh.
  localparam int PROG_HI_POS = 3; // Program block 8000h-ffffh.
  localparam int DATA_LO_POS = 6; // Data block 0000h-7fffh.
  localparam int DATA_HI_POS = 9; // Data block 8000h-ffffh.
  localparam int IO_POS = 12; // Whole I/O space.
  localparam int EXT_POS = 15; // Doubles the count on extended variants.
  localparam logic [15:0] WAIT_CFG_RST = 16'h7fff; // Seven waits everywhere after reset.
  // Bank boundary control field positions.
  localparam int BANK_MASK_POS = 12; // Bank size mask, bits 15:12 of the address.
  localparam int BANK_MASK_W = 4; // Width of the bank mask.
  localparam int BANK_EN_POS = 1; // Enables the bank-crossing idle cycle.
  localparam int PD_EN_POS = 0; // Enables the program-to-data idle cycle.
  localparam logic [15:0] BANK_CFG_RST = 16'hf003; // 4K-word banks, both enables set.
  localparam logic [3:0] MAX_WAIT = 4'he; // Largest stretch, fourteen cycles.
  // Address spaces.
  typedef enum logic [1:0] {EWB_PROG = 2'h0, EWB_DATA = 2'h1, EWB_IO = 2'h2} ewb_space_t;
  // One access request from the core.
  typedef struct packed {
    logic valid; // Request present.
    logic ext; // Access goes off chip.
    logic write; // Write access.
    ewb_space_t space; // Address space.
    logic [15:0] addr; // Word address.
    logic [15:0] wdata; // Write data.
  } ewb_req_t;
  // Bus controller states.
  typedef enum logic [3:0] {
    EWB_IDLE = 4'h1, EWB_GAP = 4'h2, EWB_WAIT = 4'h4, EWB_DONE = 4'h8
  } ewb_state_t;
endpackage

/* src/ewb_sync.sv */
// Two flip-flop synchroniser for one pin level.
module ewb_sync (
  input wire logic core_clk, // Machine clock.
  input wire logic rst, // Asynchronous reset, active high.
  input wire logic d, // Asynchronous level in.
  output logic q // Synchronised level out.
);
  logic meta; // First stage, read only by the second.
  // Two stages clear reset to the ready-asserted level is not assumed; both reset low.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      meta <= 1'b0;
      q <= 1'b0;
    end else begin
      meta <= d;
      q <= meta;
    end
  end
endmodule

/* src/ewb_top.sv */
// External bus wait-state generator and bank switching control.
// Contract
// - Stretch external cycles by programmed waits, up to 7/14.
// - Separate 0-7 count per 32K program/data block.
// - One common count for whole I/O space.
// - Waits generated internally, no external circuitry.
// - Idle cycle on bank boundary crossing.
// - Idle cycle on program-to-data transition.
// - Bank size from bank boundary control register.
// - External ready extends cycles beyond software waits.
// - Separate data, program, I/O select strobes.
module ewb_top import ewb_pkg::*; (
  input wire logic core_clk, // Machine clock, 10 MHz.
  input wire logic rst, // Asynchronous reset, active high.
  input wire logic [1:0] reg_addr, // Register index.
  input wire logic [15:0] reg_wdata, // Register write data.
  input wire logic reg_wr, // Register write strobe.
  input wire logic reg_rd, // Register read strobe.
  output logic [15:0] reg_rdata, // Read data, one cycle after the strobe.
  input wire ewb_req_t req, // Access request from the core.
  output logic req_ready, // Request taken this cycle.
  output logic done, // Access completes this cycle.
  output logic [15:0] rdata, // Read data returned to the core.
  output logic [15:0] ext_addr, // External address bus.
  output logic [15:0] ext_data_o, // External data out.
  output logic ext_data_oe, // External data drive enable.
  input wire logic [15:0] ext_data_i, // External data in.
  output logic ext_rw_n, // High for read, low for write.
  output logic data_space_select_n, // Data space select, active low.
  output logic program_space_select_n, // Program space select, active low.
  output logic io_space_select_n, // I/O space select, active low.
  input wire logic ext_ready // External ready pin, high when ready.
);
  logic [15:0] wait_count_config_reg; // Per-block wait counts.
  logic [15:0] bank_boundary_control_reg; // Bank size and gap enables.
  ewb_state_t state; // Controller state.
  ewb_state_t next_state; // Next controller state.
  ewb_req_t cur; // Access in progress.
  logic [3:0] wait_cnt; // Waits still to run.
  logic [3:0] next_wait; // Wait count for a new request.
  logic need_gap; // A new request needs an idle cycle first.
  logic last_valid; // A previous external access exists.
  ewb_space_t last_space; // Space of previous external access.
  logic [3:0] last_bank; // Bank address bits of previous external access, unmasked.
  logic ready_s; // Synchronised ready.
  logic [2:0] field; // Selected 3-bit count.
  logic active_ext; // An external cycle is on the bus.

  // Ready pin crosses in through two flip-flops.
  ewb_sync u_sync (
    .core_clk(core_clk),
    .rst(rst),
    .d(ext_ready),
    .q(ready_s)
  );

  // Select the count for the request block; I/O uses one field for all of it.
  always_comb begin
    if (req.space == EWB_IO) begin
      field = wait_count_config_reg[IO_POS +: 3];
    end else if (req.space == EWB_PROG) begin
      field = req.addr[15] ? wait_count_config_reg[PROG_HI_POS +: 3] :
              wait_count_config_reg[PROG_LO_POS +: 3];
    end else begin
      field = req.addr[15] ? wait_count_config_reg[DATA_HI_POS +: 3] :
              wait_count_config_reg[DATA_LO_POS +: 3];
    end
    // The extended flag doubles the stretch, reaching fourteen.
    next_wait = wait_count_config_reg[EXT_POS] ? {field, 1'b0} : {1'b0, field};
  end

  // Decide whether an idle cycle must precede the new external access.
  always_comb begin
    need_gap = 1'b0;
    if (req.valid && req.ext && last_valid) begin
      if (bank_boundary_control_reg[BANK_EN_POS] && req.space == last_space &&
          req.space != EWB_IO &&
          (req.addr[15:12] & bank_boundary_control_reg[BANK_MASK_POS +: BANK_MASK_W]) !=
          (last_bank & bank_boundary_control_reg[BANK_MASK_POS +: BANK_MASK_W])) begin
        need_gap = 1'b1;
      end else if (bank_boundary_control_reg[PD_EN_POS] && last_space == EWB_PROG &&
                   req.space == EWB_DATA) begin
        need_gap = 1'b1;
      end
    end
  end

  // Request acceptance is combinational: only in idle.
  assign req_ready = (state == EWB_IDLE);

  // Next state logic.
  always_comb begin
    next_state = state;
    case (state)
      EWB_IDLE: begin
        if (req.valid && !req.ext) begin
          next_state = EWB_DONE;
        end else if (req.valid && need_gap) begin
          next_state = EWB_GAP;
        end else if (req.valid) begin
          next_state = EWB_WAIT;
        end
      end
      EWB_GAP: begin
        next_state = EWB_WAIT;
      end
      EWB_WAIT: begin
        // Finish once software waits are spent and ready is high.
        if (wait_cnt == 4'h0 && ready_s) begin
          next_state = EWB_DONE;
        end
      end
      EWB_DONE: begin
        next_state = EWB_IDLE;
      end
      default: begin
        next_state = EWB_IDLE;
      end
    endcase
  end

  // State register.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state <= EWB_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // Capture the request and count down the software waits.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      cur <= '0;
      wait_cnt <= 4'h0;
    end else if (state == EWB_IDLE && req.valid) begin
      cur <= req;
      wait_cnt <= req.ext ? next_wait : 4'h0;
    end else if (state == EWB_WAIT && wait_cnt != 4'h0) begin
      wait_cnt <= wait_cnt - 4'h1;
    end
  end

  // Remember space and bank of the last external access for gap decisions.
  // The bank bits are kept unmasked so that a newly written bank size applies at once.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      last_valid <= 1'b0;
      last_space <= EWB_PROG;
      last_bank <= 4'h0;
    end else if (state == EWB_IDLE && req.valid && req.ext) begin
      last_valid <= 1'b1;
      last_space <= req.space;
      last_bank <= req.addr[15:12];
    end
  end

  // Drive the external pins only for real external cycles.
  assign active_ext = (state == EWB_WAIT); // The selects are low exactly in this state.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      ext_addr <= 16'h0000;
      ext_data_o <= 16'h0000;
      ext_data_oe <= 1'b0;
      ext_rw_n <= 1'b1;
      data_space_select_n <= 1'b1;
      program_space_select_n <= 1'b1;
      io_space_select_n <= 1'b1;
    end else if (next_state == EWB_WAIT) begin
      ext_addr <= (state == EWB_IDLE) ? req.addr : cur.addr;
      ext_data_o <= (state == EWB_IDLE) ? req.wdata : cur.wdata;
      ext_data_oe <= (state == EWB_IDLE) ? req.write : cur.write;
      ext_rw_n <= !((state == EWB_IDLE) ? req.write : cur.write);
      // One select per space, decoded from the access being started.
      data_space_select_n <= !(((state == EWB_IDLE) ? req.space : cur.space) == EWB_DATA);
      program_space_select_n <= !(((state == EWB_IDLE) ? req.space : cur.space) == EWB_PROG);
      io_space_select_n <= !(((state == EWB_IDLE) ? req.space : cur.space) == EWB_IO);
    end else begin
      ext_data_oe <= 1'b0;
      ext_rw_n <= 1'b1;
      data_space_select_n <= 1'b1;
      program_space_select_n <= 1'b1;
      io_space_select_n <= 1'b1;
    end
  end

  // Completion pulse and captured read data.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      rdata <= 16'h0000;
    end else if (state == EWB_WAIT && next_state == EWB_DONE && !cur.write) begin
      rdata <= ext_data_i;
    end
  end
  assign done = (state == EWB_DONE);

  // Register writes.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      wait_count_config_reg <= WAIT_CFG_RST;
      bank_boundary_control_reg <= BANK_CFG_RST;
    end else if (reg_wr) begin
      if (reg_addr == WAIT_CFG_OFS) begin
        wait_count_config_reg <= reg_wdata;
      end else if (reg_addr == BANK_CFG_OFS) begin
        bank_boundary_control_reg <= reg_wdata;
      end
    end
  end

  // Register reads, data one cycle after the strobe; unmapped reads zero.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      reg_rdata <= 16'h0000;
    end else if (reg_rd) begin
      if (reg_addr == WAIT_CFG_OFS) begin
        reg_rdata <= wait_count_config_reg;
      end else if (reg_addr == BANK_CFG_OFS) begin
        reg_rdata <= bank_boundary_control_reg;
      end else if (reg_addr == STATUS_OFS) begin
        reg_rdata <= {7'h00, ready_s, last_valid, last_space, wait_cnt, state == EWB_GAP};
      end else begin
        reg_rdata <= 16'h0000;
      end
    end else begin
      reg_rdata <= 16'h0000;
    end
  end

  // On-chip accesses finish the cycle after acceptance.
  property onchip_fast;
    @(posedge core_clk) disable iff (rst)
      (state == EWB_IDLE && req.valid && !req.ext) |=> done;
  endproperty
  onchip_fast_a: assert property (onchip_fast) else $error("on-chip access delayed");

  // A gap cycle always follows a detected boundary crossing.
  gap_inserted_a: assert property (@(posedge core_clk) disable iff (rst)
    (state == EWB_IDLE && need_gap) |=> state == EWB_GAP)
    else $error("missing idle cycle");

  // During a gap no select is driven.
  gap_quiet_a: assert property (@(posedge core_clk) disable iff (rst)
    state == EWB_GAP |-> (data_space_select_n && program_space_select_n &&
    io_space_select_n && !ext_data_oe))
    else $error("bus driven in idle cycle");

  // Completion needs synchronised ready.
  ready_hold_a: assert property (@(posedge core_clk) disable iff (rst)
    (state == EWB_WAIT && !ready_s) |=> state != EWB_DONE)
    else $error("completed without ready");

  // Waits never exceed the maximum stretch.
  wait_max_a: assert property (@(posedge core_clk) disable iff (rst)
    wait_cnt <= MAX_WAIT)
    else $error("wait count above limit");

  // Waits count down by exactly one while stretching.
  wait_step_a: assert property (@(posedge core_clk) disable iff (rst)
    (state == EWB_WAIT && wait_cnt != 4'h0) |=> wait_cnt == $past(wait_cnt) - 4'h1)
    else $error("wait count not stepping");

  // At most one select active.
  one_select_a: assert property (@(posedge core_clk) disable iff (rst)
    $onehot0({!data_space_select_n, !program_space_select_n, !io_space_select_n}))
    else $error("several selects active");

  // Selects stay high outside external cycles, so on-chip work never reaches the pins.
  sel_window_a: assert property (@(posedge core_clk) disable iff (rst)
    !active_ext |-> (data_space_select_n && program_space_select_n &&
    io_space_select_n))
    else $error("select outside external cycle");

  // I/O requests load the common I/O field.
  io_count_a: assert property (@(posedge core_clk) disable iff (rst)
    (state == EWB_IDLE && req.valid && req.ext && req.space == EWB_IO &&
     !wait_count_config_reg[EXT_POS]) |=> wait_cnt == {1'b0, $past(wait_count_config_reg[IO_POS +: 3])})
    else $error("wrong I/O wait count");

  // Program requests with address bit 15 set load the upper program block count.
  blk_count_a: assert property (@(posedge core_clk) disable iff (rst)
    (state == EWB_IDLE && req.valid && req.ext && req.space == EWB_PROG &&
     req.addr[15] && !wait_count_config_reg[EXT_POS]) |=>
    wait_cnt == {1'b0, $past(wait_count_config_reg[PROG_HI_POS +: 3])})
    else $error("wrong block wait count");
endmodule

/* test/ewb_mem_model.sv */
// Behavioural external memory and I/O device that answers the bus of the wait and bank block.
module ewb_mem_model import ewb_pkg::*; (
  input wire logic core_clk, // Machine clock.
  input wire logic rst, // Asynchronous reset, active high.
  input wire logic [15:0] ext_addr, // Address from the block.
  input wire logic [15:0] ext_data_o, // Write data from the block.
  input wire logic ext_data_oe, // Block drives the data bus.
  input wire logic ext_rw_n, // High for read, low for write.
  input wire logic data_space_select_n, // Data space select, active low.
  input wire logic program_space_select_n, // Program space select, active low.
  input wire logic io_space_select_n, // I/O space select, active low.
  input wire logic [3:0] slow_cnt, // Not-ready count; a nonzero n holds ready low for n+1 cycles at the start of each access.
  output logic [15:0] ext_data_i, // Read data back to the block.
  output logic ext_ready, // Ready pin, high when ready.
  output logic [2:0] last_sel, // Selects seen in the last access, {io, prog, data}.
  output logic [7:0] n_acc, // Number of accesses seen.
  output logic saw_oe // Drive enable seen during the last write.
);
  logic sel; // Any space selected.
  logic sel_q; // Select state one cycle ago.
  logic [3:0] rdy_cnt; // Remaining not-ready cycles.
  logic [17:0] key; // Space and address of the current access.
  logic [17:0] wr_key; // Space and address of the last write.
  logic [15:0] wr_val; // Value of the last write.
  logic [15:0] hold; // Last value seen on the read bus.
  assign sel = ~(data_space_select_n & program_space_select_n & io_space_select_n);
  assign key = {~io_space_select_n, ~data_space_select_n, ext_addr};
  // Drive only while selected for a read; a released bus flips every cycle so no stale value lingers.
  assign ext_data_i = (sel && ext_rw_n) ? ((key == wr_key) ? wr_val : ~ext_addr) : ~hold;
  // A slow device holds ready low at the start of each access.
  // Ready falls as soon as the device is selected and stays low while the count runs.
  assign ext_ready = !(sel && (sel_q ? (rdy_cnt != 4'h0) : (slow_cnt != 4'h0)));
  // Tracks access starts, the not-ready count and the last write.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      sel_q <= 1'b0;
      hold <= 16'h0000;
      rdy_cnt <= 4'h0;
      n_acc <= 8'h00;
      last_sel <= 3'h0;
      wr_key <= 18'h3ffff;
      wr_val <= 16'h0000;
      saw_oe <= 1'b0;
    end else begin
      sel_q <= sel;
      hold <= ext_data_i;
      if (sel && !sel_q) begin
        // A new access starts.
        n_acc <= n_acc + 8'h01;
        last_sel <= {~io_space_select_n, ~program_space_select_n, ~data_space_select_n};
        rdy_cnt <= slow_cnt;
      end else if (sel && rdy_cnt != 4'h0) begin
        rdy_cnt <= rdy_cnt - 4'h1;
      end
      if (sel && !ext_rw_n) begin
        // Captures write data and whether the block drove the bus.
        wr_key <= key;
        wr_val <= ext_data_o;
        saw_oe <= ext_data_oe;
      end
    end
  end
endmodule

/* test/ewb_top_tb_top.sv */
// Self-checking testbench for the external bus wait and bank control block.
module ewb_top_tb_top import ewb_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  logic core_clk = 1'b0; // Machine clock, 100 ns period.
  logic rst = 1'b1; // Reset, active high.
  logic [1:0] reg_addr = 2'h0; // Register index.
  logic [15:0] reg_wdata = 16'h0000; // Register write data.
  logic reg_wr = 1'b0; // Register write strobe.
  logic reg_rd = 1'b0; // Register read strobe.
  logic [15:0] reg_rdata, rdata, ext_addr, ext_data_o, ext_data_i;
  ewb_req_t req = '0; // Access request.
  logic req_ready, done, ext_data_oe, ext_rw_n, ext_ready, saw_oe;
  logic data_sel_n, prog_sel_n, io_sel_n; // Space selects, active low.
  logic [3:0] slow_cnt = 4'h0; // Not-ready count asked of the partner, n+1 low cycles when nonzero.
  logic [2:0] last_sel; // Selects seen by the partner.
  logic [7:0] n_acc; // Accesses seen by the partner.
  int error_cnt = 0; // Mismatches.
  int n_tests = 0; // Comparisons.
  int lat; // Cycles from take to done.
  always #50 core_clk = ~core_clk;
  ewb_top ewb_top_i (.core_clk(core_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .req(req), .req_ready(req_ready),
    .done(done), .rdata(rdata), .ext_addr(ext_addr), .ext_data_o(ext_data_o),
    .ext_data_oe(ext_data_oe), .ext_data_i(ext_data_i), .ext_rw_n(ext_rw_n),
    .data_space_select_n(data_sel_n), .program_space_select_n(prog_sel_n),
    .io_space_select_n(io_sel_n),
    .ext_ready(ext_ready));
  ewb_mem_model ewb_mem_model_i (.core_clk(core_clk), .rst(rst), .ext_addr(ext_addr),
    .ext_data_o(ext_data_o), .ext_data_oe(ext_data_oe), .ext_rw_n(ext_rw_n),
    .data_space_select_n(data_sel_n), .program_space_select_n(prog_sel_n),
    .io_space_select_n(io_sel_n),
    .slow_cnt(slow_cnt), .ext_data_i(ext_data_i), .ext_ready(ext_ready), .last_sel(last_sel),
    .n_acc(n_acc), .saw_oe(saw_oe));
  // Compares a 16-bit value.
  task automatic chk16(input string nm, input logic [15:0] e, input logic [15:0] g);
    n_tests++;
    if (g !== e) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  // Compares a single bit.
  task automatic chkb(input string nm, input logic e, input logic g);
    n_tests++;
    if (g !== e) begin
      error_cnt++;
      $display("ERROR %s expected %b seen %b", nm, e, g);
    end
  endtask
  // One-cycle register write.
  task automatic reg_write(input logic [1:0] a, input logic [15:0] d);
    @(posedge core_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask
  // One-cycle register read, data checked in the following cycle.
  task automatic reg_check(input logic [1:0] a, input logic [15:0] e);
    @(posedge core_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 chk16("reg_rdata", e, reg_rdata);
  endtask
  // Makes one access; lat counts the taking edge as one, then each edge up to done.
  // Done is looked at just after the taking edge too, since an on-chip pulse stands there.
  task automatic acc(input ewb_space_t sp, input logic e, input logic w, input logic [15:0] a,
    input logic [15:0] d);
    @(posedge core_clk);
    req <= '{1'b1, e, w, sp, a, d};
    do @(posedge core_clk); while (req_ready !== 1'b1);
    req.valid <= 1'b0;
    lat = 1;
    #1;
    while (done !== 1'b1 && lat < 40) begin
      @(posedge core_clk);
      lat++;
      #1;
    end
  endtask
  // External read whose latency and returned data are checked.
  task automatic rd(input ewb_space_t sp, input logic [15:0] a, input int e);
    acc(sp, 1'b1, 1'b0, a, 16'h0000);
    chk16("latency", 16'(e), 16'(lat));
    chk16("rdata", ~a, rdata);
  endtask
  // Reset state and register access.
  task automatic t_reset();
    chkb("selects idle", 1'b1, data_sel_n & prog_sel_n & io_sel_n);
    reg_check(WAIT_CFG_OFS, WAIT_CFG_RST);
    reg_check(BANK_CFG_OFS, BANK_CFG_RST);
    reg_check(2'h3, 16'h0000);
    reg_check(STATUS_OFS, 16'h0100);
  endtask
  // Separate counts per program and data block and one for I/O.
  task automatic t_waits();
    ewb_space_t sp[6] = '{EWB_PROG, EWB_PROG, EWB_DATA, EWB_DATA, EWB_IO, EWB_IO};
    logic [15:0] ad[6] = '{16'h0100, 16'h8100, 16'h0100, 16'h9000, 16'h1234, 16'hf000};
    logic [2:0] se[6] = '{3'h2, 3'h2, 3'h1, 3'h1, 3'h4, 3'h4};
    int ex[6] = '{3, 4, 5, 6, 7, 7};
    reg_write(BANK_CFG_OFS, 16'h0000);
    reg_write(WAIT_CFG_OFS, 16'h58d1);
    for (int i = 0; i < 6; i++) begin
      rd(sp[i], ad[i], ex[i]);
      chk16("select", 16'(se[i]), 16'(last_sel));
    end
  endtask
  // Largest counts, base and doubled.
  task automatic t_max();
    reg_write(WAIT_CFG_OFS, 16'h7000);
    rd(EWB_IO, 16'h0007, 9);
    reg_write(WAIT_CFG_OFS, 16'hf000);
    rd(EWB_IO, 16'h0008, 16);
    rd(EWB_PROG, 16'h0009, 2);
  endtask
  // On-chip accesses get neither waits nor gaps and never select a space.
  task automatic t_onchip();
    logic [7:0] n0;
    reg_write(WAIT_CFG_OFS, 16'h7fff);
    reg_write(BANK_CFG_OFS, 16'hf003);
    n0 = n_acc;
    acc(EWB_PROG, 1'b0, 1'b0, 16'h0010, 16'h0000);
    chk16("on-chip latency", 16'h0001, 16'(lat));
    acc(EWB_DATA, 1'b0, 1'b0, 16'h2010, 16'h0000);
    chk16("on-chip latency", 16'h0001, 16'(lat));
    chk16("bus accesses", n0, n_acc);
  endtask
  // Bank crossing with two bank sizes, then program to data.
  task automatic t_gaps();
    reg_write(WAIT_CFG_OFS, 16'h0000);
    reg_write(BANK_CFG_OFS, 16'hf002);
    acc(EWB_DATA, 1'b1, 1'b0, 16'h1000, 16'h0000);
    rd(EWB_DATA, 16'h1001, 2);
    rd(EWB_DATA, 16'h2000, 3);
    reg_write(BANK_CFG_OFS, 16'h8002);
    rd(EWB_DATA, 16'h3000, 2);
    rd(EWB_DATA, 16'h9000, 3);
    rd(EWB_PROG, 16'h0000, 2);
    rd(EWB_PROG, 16'h8000, 3);
    reg_write(BANK_CFG_OFS, 16'h0001);
    rd(EWB_DATA, 16'h0010, 3);
    rd(EWB_DATA, 16'h0020, 2);
    rd(EWB_PROG, 16'h0010, 2);
    reg_write(BANK_CFG_OFS, 16'h0000);
    rd(EWB_DATA, 16'h0030, 2);
  endtask
  // Write then read back, and a slow device holding ready low.
  task automatic t_write_ready();
    acc(EWB_DATA, 1'b1, 1'b1, 16'h0042, 16'hbeef);
    chk16("write latency", 16'h0002, 16'(lat));
    chkb("drive enable", 1'b1, saw_oe);
    acc(EWB_DATA, 1'b1, 1'b0, 16'h0042, 16'h0000);
    chk16("read back", 16'hbeef, rdata);
    // Two software waits give the synchronised ready time to hold the cycle.
    reg_write(WAIT_CFG_OFS, 16'h2000);
    slow_cnt <= 4'h4;
    acc(EWB_IO, 1'b1, 1'b0, 16'h0055, 16'h0000);
    chkb("ready stretch", 1'b1, lat >= 5 && lat <= 12);
    chk16("slow rdata", ~16'h0055, rdata);
    slow_cnt <= 4'h0;
  endtask
  // Prints the counts and the verdict, then stops.
  task automatic end_of_test();
    $display("Comparisons %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // Main sequence.
  initial begin
    repeat (6) @(posedge core_clk);
    rst <= 1'b0;
    t_reset();
    t_waits();
    t_max();
    t_onchip();
    t_gaps();
    t_write_ready();
    end_of_test();
  end
  // Cuts a hang short well beyond the expected run of about 160 cycles.
  initial begin
    #2000000;
    error_cnt++;
    end_of_test();
  end
endmodule
